// File: dv/sbt_jtag_model.sv
`timescale 1ns/1ps
module sbt_jtag_model (
   input wire i_tdo,
   input wire i_tdo_oe,
   output reg o_tck,
   output reg o_tms,
   output reg o_tdi
);
   // tck stands low between frames; tms and tdi idle at the pull-up level
   initial
   begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end
   // one tck period; tdo is taken at the rise, a floating tdo reads inverted
   task step(input t, input d, output q);
   begin
      o_tms = t;
      o_tdi = d;
      #400;
      q = i_tdo_oe ? i_tdo : ~i_tdo;
      o_tck = 1'b1;
      #400;
      o_tck = 1'b0;
   end
   endtask
endmodule // sbt_jtag_model

// File: dv/sbt_tap_asserts.sv
`timescale 1ns/1ps
`include "sbt_defines.vh"
module sbt_tap_asserts (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_tck,
   input wire i_tms,
   input wire o_tdo,
   input wire o_tdo_oe,
   input wire o_extest,
   input wire [`SBT_BSR_W-1:0] o_pin_drive,
   input wire o_bus_oe,
   input wire o_bus_float
);
   // counts tck rises seen with tms high, saturating at five
   reg [2:0] n_hi;
   reg tck_q;
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         n_hi <= 3'h0;
         tck_q <= 1'b0;
      end
      else
      begin
         tck_q <= i_tck;
         if (i_tck && !tck_q)
            n_hi <= !i_tms ? 3'h0 : (n_hi == 3'h5 ? n_hi : n_hi + 3'h1);
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_tdo_fall: assert property ($changed(o_tdo) |-> !i_tck && $past(!i_tck, 2))
      else $error("tdo moved outside tck low");
   a_oe_fall: assert property ($changed(o_tdo_oe) |-> !i_tck && $past(!i_tck, 2))
      else $error("tdo enable moved outside tck low");
   a_drive_idle: assert property ($changed(o_pin_drive) |-> !o_tdo_oe)
      else $error("pin drive changed while shifting");
   a_cell_gate: assert property ($fell(o_bus_oe) |-> !o_tdo_oe)
      else $error("bus enable dropped while shifting");
   a_extest_float: assert property (o_extest |-> o_bus_float == !o_bus_oe)
      else $error("bus float wrong under extest");
   a_ir_update: assert property ($changed(o_extest) |-> !o_tdo_oe)
      else $error("instruction changed while shifting");
   a_rst_idle: assert property ($rose(i_rst_n) |-> !o_tdo_oe && o_bus_oe && !o_extest)
      else $error("outputs not idle after reset");
   a_tap_reset: assert property ($rose(n_hi == 3'h5) |-> ##6 (!o_extest && o_bus_oe && !o_tdo_oe))
      else $error("five high tms edges did not reset");
endmodule // sbt_tap_asserts
bind sbt_tap sbt_tap_asserts i_sbt_tap_asserts (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tck(i_tck),
   .i_tms(i_tms), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_extest(o_extest), .o_pin_drive(o_pin_drive),
   .o_bus_oe(o_bus_oe), .o_bus_float(o_bus_float));

// File: dv/sbt_tap_tb_top.sv
`timescale 1ns/1ps
`include "sbt_defines.vh"
module sbt_tap_tb_top;
   localparam [31:0] ID = 32'hA5C3_0F11; // arbitrary value, lsb one
   reg i_clk;
   reg i_rst_n;
   reg [`SBT_BSR_W-1:0] ring;
   reg [`SBT_BSR_W-1:0] q;
   reg ce;
   wire tck, tms, tdi, tdo, tdo_oe, ext, boe, bfl;
   wire [`SBT_BSR_W-1:0] drv;
   integer n_errors = 0;
   integer n_compared = 0;
   integer cyc = 0;
   integer c;
   sbt_tap #(.ID_CODE(ID)) i_sbt_tap (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_tck(tck),
      .i_tms(tms), .i_tdi(tdi), .i_pin_ring(ring), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_extest(ext),
      .o_pin_drive(drv), .o_bus_oe(boe), .o_bus_float(bfl));
   sbt_jtag_model i_sbt_jtag_model (.i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
   task results;
   begin
      if (n_errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask
   task chk(input string nm, input [`SBT_BSR_W-1:0] e, input [`SBT_BSR_W-1:0] g);
   begin
      n_compared = n_compared + 1;
      if (g !== e)
      begin
         n_errors = n_errors + 1;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   end
   endtask
   // from idle through capture, n shift bits, update, back to idle
   task scan(input ir, input integer n, input [`SBT_BSR_W-1:0] d);
      integer i;
      reg b;
   begin
      i_sbt_jtag_model.step(1'b1, 1'b1, b);
      if (ir)
         i_sbt_jtag_model.step(1'b1, 1'b1, b);
      i_sbt_jtag_model.step(1'b0, 1'b1, b);
      i_sbt_jtag_model.step(1'b0, 1'b1, b);
      for (i = 0; i < n; i = i + 1)
      begin
         i_sbt_jtag_model.step(i == n - 1, d[i], b);
         q[i] = b;
      end
      i_sbt_jtag_model.step(1'b1, 1'b1, b);
      i_sbt_jtag_model.step(1'b0, 1'b1, b);
   end
   endtask
   task t_bypass;
   begin
      scan(1, 3, `SBT_INS_BYPASS);
      chk("ir capture", 2'h1, q[1:0]);
      scan(0, 2, 2'h3);
      chk("bypass", 2'h2, q[1:0]);
      for (c = 3; c < 7; c = c + 1 + (c == 3))
      begin
         scan(1, 3, c);
         scan(0, 2, 2'h3);
         chk("reserved", 2'h2, q[1:0]);
      end
   end
   endtask
   task t_preload;
   begin
      scan(1, 3, `SBT_INS_PRELOAD);
      scan(0, `SBT_BSR_W, {1'b0, {27{4'h3}}});
      chk("ring", ring, q);
      chk("pin drive", {1'b0, {27{4'h3}}}, drv);
      scan(1, 3, `SBT_INS_EXTEST);
      chk("extest float", 3'h5, {ext, boe, bfl});
      scan(1, 3, `SBT_INS_SAMPLEZ);
      chk("sample float", 3'h1, {ext, boe, bfl});
      ce = 1'b0;
      scan(1, 3, `SBT_INS_EXTEST);
      ce = 1'b1;
      chk("frozen float", 3'h1, {ext, boe, bfl});
   end
   endtask
   task t_tms_reset;
      reg b;
   begin
      repeat (5) i_sbt_jtag_model.step(1'b1, 1'b1, b);
      chk("tap reset", 3'h2, {ext, boe, bfl});
      i_sbt_jtag_model.step(1'b0, 1'b1, b);
      scan(0, 32, 0);
      chk("idcode again", ID, q[31:0]);
   end
   endtask
   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         n_errors = n_errors + 1;
         results;
      end
   end
   initial
   begin
      i_rst_n = 1'b0;
      ring = {1'b1, {27{4'hC}}};
      q = 0;
      ce = 1'b1;
      repeat (3) @(posedge i_clk);
      #5 i_rst_n = 1'b1;
      repeat (4) @(posedge i_clk);
      #5 chk("tdo enable", 1'b0, tdo_oe);
      i_sbt_jtag_model.step(1'b0, 1'b1, q[0]);
      scan(0, 32, 0);
      chk("idcode", ID, q[31:0]);
      t_bypass;
      t_preload;
      t_tms_reset;
      results;
   end
endmodule // sbt_tap_tb_top

// File: logic/sbt_defines.vh
`ifndef SBT_DEFINES_VH
`define SBT_DEFINES_VH

// instruction register width and codes
`define SBT_IR_W 3
`define SBT_INS_EXTEST 3'h0
`define SBT_INS_IDCODE 3'h1
`define SBT_INS_SAMPLEZ 3'h2
`define SBT_INS_PRELOAD 3'h4
`define SBT_INS_BYPASS 3'h7
// pattern captured into the low instruction bits
`define SBT_IR_CAPTURE 2'h1
// scan lengths
`define SBT_ID_W 32
`define SBT_BSR_W 109
// cell that gates the output bus under external test
`define SBT_OE_CELL 108
// consecutive high mode-select edges that reach reset
`define SBT_RESET_EDGES 5

`endif

// File: logic/sbt_tap.v
`timescale 1ns/1ps
`include "sbt_defines.vh"

// Overview of operation
// - sample on rising, update on falling edge; the code updates on the rising edge, only tdo and its enable move on falling
// - sample mode select; inputs pulled high
// - serial in at MSB, out at LSB
// - instruction selects the scan register
// - drive serial out only while shifting
// - five high mode-select edges reset controller
// - power-up reset floats serial output
// - exactly one register in scan path
// - three-bit instruction register loaded serially
// - identification instruction loaded on reset
// - instruction capture loads pattern 01
// - one-bit bypass register provided
// - bypass cleared when bypass takes effect
// - capture pin ring, shift boundary register
// - capture under extest, preload, sample-float
// - one boundary cell per bump
// - identification code captured then shifted
// - identification code hardwired and fixed
// - all eight codes decoded, three reserved
// - sample-float floats memory output bus
// - extest drives preloaded values onto pins
// - cell 108 gates bus, preset high
module sbt_tap #(
   parameter [31:0] ID_CODE = 32'h1234_5679 // arbitrary value, lsb one; the logic does not force the lsb
)(
   input wire i_clk,
   input wire i_rst_n,
   input wire i_ce,
   input wire i_tck,
   input wire i_tms,
   input wire i_tdi,
   input wire [`SBT_BSR_W-1:0] i_pin_ring,
   output reg o_tdo,
   output reg o_tdo_oe,
   output wire o_extest,
   output wire [`SBT_BSR_W-1:0] o_pin_drive,
   output wire o_bus_oe,
   output wire o_bus_float
);

   // ----------------------------------------
   // state codes
   // ----------------------------------------
   // one-hot, one flop per state; each state test compares the full sixteen-bit vector
   localparam [15:0] ST_TLR = 16'h0001;
   localparam [15:0] ST_RTI = 16'h0002;
   localparam [15:0] ST_SDS = 16'h0004;
   localparam [15:0] ST_CDR = 16'h0008;
   localparam [15:0] ST_SDR = 16'h0010;
   localparam [15:0] ST_E1D = 16'h0020;
   localparam [15:0] ST_PDR = 16'h0040;
   localparam [15:0] ST_E2D = 16'h0080;
   localparam [15:0] ST_UDR = 16'h0100;
   localparam [15:0] ST_SIS = 16'h0200;
   localparam [15:0] ST_CIR = 16'h0400;
   localparam [15:0] ST_SIR = 16'h0800;
   localparam [15:0] ST_E1I = 16'h1000;
   localparam [15:0] ST_PIR = 16'h2000;
   localparam [15:0] ST_E2I = 16'h4000;
   localparam [15:0] ST_UIR = 16'h8000;

   // ----------------------------------------
   // reset and input synchronisers
   // ----------------------------------------
   reg rst_meta;
   reg rst_sync;
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // pull-ups: a floating pin is modelled as reset-high meta state
   reg [2:0] pin_meta;
   reg [2:0] pin_sync;
   reg tck_prev;
   always @(posedge i_clk or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         pin_meta <= 3'h6;
         pin_sync <= 3'h6;
         tck_prev <= 1'b0;
      end
      else if (i_ce)
      begin
         pin_meta <= {i_tms, i_tdi, i_tck};
         pin_sync <= pin_meta;
         tck_prev <= pin_sync[0];
      end
   end

   wire tms = pin_sync[2];
   wire tdi = pin_sync[1];
   // a clock held low never makes an edge, so the port stays idle
   // a low enable masks both edges as well as freezing the flops
   wire tck_rise = i_ce & pin_sync[0] & ~tck_prev;
   wire tck_fall = i_ce & ~pin_sync[0] & tck_prev;
   // tck is only sampled, so each level must last a full system clock or an edge is lost

   // ----------------------------------------
   // pin ring synchroniser
   // ----------------------------------------
   // the ring moves on the memory clock; two flops per cell keep a capture from
   // catching a cell in transition, at the cost of two cycles of lag
   wire [`SBT_BSR_W-1:0] ring_sync;
   genvar g;
   generate
      for (g = 0; g < `SBT_BSR_W; g = g + 1)
      begin : g_ring
         reg cell_meta;
         reg cell_sync;
         always @(posedge i_clk or negedge rst_sync)
         begin
            if (!rst_sync)
            begin
               cell_meta <= 1'b0;
               cell_sync <= 1'b0;
            end
            else if (i_ce)
            begin
               cell_meta <= i_pin_ring[g];
               cell_sync <= cell_meta;
            end
         end
         assign ring_sync[g] = cell_sync;
      end
   endgenerate

   // ----------------------------------------
   // controller
   // ----------------------------------------
   reg [15:0] state;
   reg [15:0] next_state;
   always @*
   begin
      case (state)
         ST_TLR: next_state = tms ? ST_TLR : ST_RTI;
         ST_RTI: next_state = tms ? ST_SDS : ST_RTI;
         ST_SDS: next_state = tms ? ST_SIS : ST_CDR;
         ST_CDR: next_state = tms ? ST_E1D : ST_SDR;
         ST_SDR: next_state = tms ? ST_E1D : ST_SDR;
         ST_E1D: next_state = tms ? ST_UDR : ST_PDR;
         ST_PDR: next_state = tms ? ST_E2D : ST_PDR;
         ST_E2D: next_state = tms ? ST_UDR : ST_SDR;
         ST_UDR: next_state = tms ? ST_SDS : ST_RTI;
         ST_SIS: next_state = tms ? ST_TLR : ST_CIR;
         ST_CIR: next_state = tms ? ST_E1I : ST_SIR;
         ST_SIR: next_state = tms ? ST_E1I : ST_SIR;
         ST_E1I: next_state = tms ? ST_UIR : ST_PIR;
         ST_PIR: next_state = tms ? ST_E2I : ST_PIR;
         ST_E2I: next_state = tms ? ST_UIR : ST_SIR;
         ST_UIR: next_state = tms ? ST_SDS : ST_RTI;
         default: next_state = ST_TLR;
      endcase
   end

   // ----------------------------------------
   // instruction decode
   // ----------------------------------------
   reg [`SBT_IR_W-1:0] ir;
   reg [`SBT_IR_W-1:0] ir_shift;

   // which data register sits in the scan path; reserved codes fall to bypass
   localparam [1:0] SEL_BYPASS = 2'h0;
   localparam [1:0] SEL_ID = 2'h1;
   localparam [1:0] SEL_BSR = 2'h2;

   function [1:0] sel_of;
      input [`SBT_IR_W-1:0] code;
      begin
         case (code)
            `SBT_INS_EXTEST: sel_of = SEL_BSR;
            `SBT_INS_SAMPLEZ: sel_of = SEL_BSR;
            `SBT_INS_PRELOAD: sel_of = SEL_BSR;
            `SBT_INS_IDCODE: sel_of = SEL_ID;
            default: sel_of = SEL_BYPASS;
         endcase
      end
   endfunction

   wire [1:0] dr_sel = sel_of(ir);

   // ----------------------------------------
   // scan registers, all on rising test-clock edges
   // ----------------------------------------
   reg bypass;
   reg [`SBT_ID_W-1:0] id_shift;
   reg [`SBT_BSR_W-1:0] bsr_shift;
   reg [`SBT_BSR_W-1:0] bsr_latch;
   // the code is a wire to a constant, so no scan can ever alter it
   wire [`SBT_ID_W-1:0] id_value = ID_CODE;

   always @(posedge i_clk or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         state <= ST_TLR;
         ir <= `SBT_INS_IDCODE;
         ir_shift <= `SBT_INS_IDCODE;
         bypass <= 1'b0;
         id_shift <= {`SBT_ID_W{1'b0}};
         bsr_shift <= {`SBT_BSR_W{1'b0}};
         bsr_latch <= {1'b1, {(`SBT_BSR_W-1){1'b0}}};
      end
      else if (tck_rise)
      begin
         state <= next_state;
         // act on the edge that enters reset, so five high edges are enough
         if (next_state == ST_TLR)
         begin
            ir <= `SBT_INS_IDCODE;
            bsr_latch[`SBT_OE_CELL] <= 1'b1;
         end
         if (state == ST_CIR)
            ir_shift <= {ir[`SBT_IR_W-1], `SBT_IR_CAPTURE};
         if (state == ST_SIR)
            ir_shift <= {tdi, ir_shift[`SBT_IR_W-1:1]};
         if (state == ST_UIR)
         begin
            ir <= ir_shift;
            if (sel_of(ir_shift) == SEL_BYPASS)
               bypass <= 1'b0;
         end
         if (state == ST_CDR)
         begin
            // bypass captures zero, so a chain stuck at one shows up
            bypass <= 1'b0;
            if (dr_sel == SEL_ID)
               id_shift <= id_value;
            if (dr_sel == SEL_BSR)
               bsr_shift <= ring_sync;
         end
         if (state == ST_SDR)
         begin
            case (dr_sel)
               SEL_ID: id_shift <= {tdi, id_shift[`SBT_ID_W-1:1]};
               SEL_BSR: bsr_shift <= {tdi, bsr_shift[`SBT_BSR_W-1:1]};
               default: bypass <= tdi;
            endcase
         end
         // pins only see a new pattern at update, never a half-shifted one
         if (state == ST_UDR && dr_sel == SEL_BSR)
            bsr_latch <= bsr_shift;
      end
   end

   // ----------------------------------------
   // serial output, falling test-clock edge
   // ----------------------------------------
   reg next_tdo;
   always @*
   begin
      if (state == ST_SIR)
         next_tdo = ir_shift[0];
      else
      begin
         case (dr_sel)
            SEL_ID: next_tdo = id_shift[0];
            SEL_BSR: next_tdo = bsr_shift[0];
            default: next_tdo = bypass;
         endcase
      end
   end

   always @(posedge i_clk or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         o_tdo <= 1'b0;
         o_tdo_oe <= 1'b0;
      end
      else if (tck_fall)
      begin
         o_tdo <= next_tdo;
         o_tdo_oe <= (state == ST_SIR) || (state == ST_SDR);
      end
   end

   // ----------------------------------------
   // memory-side controls
   // ----------------------------------------
   assign o_extest = (ir == `SBT_INS_EXTEST);
   assign o_pin_drive = bsr_latch;
   assign o_bus_oe = bsr_latch[`SBT_OE_CELL];
   assign o_bus_float = (ir == `SBT_INS_SAMPLEZ) || (o_extest && !o_bus_oe);

endmodule // sbt_tap
